// >>> rtl/io_register_space_decode.sv
// i/o register space decoder with bit access and write-one-to-clear flags
`timescale 1ns/1ns

// Functional notes
// - bit set and bit clear work on i/o registers 0x00 to 0x1F.
// - skip-if-high and skip-if-low test one chosen bit in that range.
// - status flags clear on a written one; a written zero leaves them.
// - bit set and clear touch only the target bit, never its neighbours.
// - bit operations above 0x1F are refused and change nothing.
// - i/o read and write decode the 64 addresses 0x00 to 0x3F.
// - load and store see i/o register n at data address n plus 0x20.
// - extended range 0x60 to 0xFF is reachable by load and store only.
module io_register_space_decode
    import io_space_pkg::*;
#(
    parameter int EXT_WORDS = EXT_DEPTH
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire req_type REQ_I,
    input wire hw_in_type HW_I,
    output rsp_type RSP_O,
    output logic [IO_SPAN-1:0][7:0] IO_REGS_O
);

    // register attributes by i/o offset
    function automatic reg_attr_type reg_attr(input logic [5:0] idx);
        case (idx)
            OFF_ACOMP_STATUS: reg_attr = ATTR_ACOMP;
            OFF_T1_MASK: reg_attr = ATTR_T1_MASK;
            OFF_T1_FLAGS: reg_attr = ATTR_T1_FLAGS;
            OFF_PB_PINS, OFF_PD_PINS: reg_attr = ATTR_PINS8;
            OFF_PE_PINS: reg_attr = ATTR_PINS3;
            OFF_PE_DIR, OFF_PE_OUT: reg_attr = ATTR_LOW3;
            OFF_ADC_CSA: reg_attr = ATTR_ADC_CSA;
            OFF_ADC_CSB: reg_attr = ATTR_ADC_CSB;
            OFF_ADC_CHSEL: reg_attr = ATTR_ADC_CHSEL;
            OFF_ST0_MASK: reg_attr = ATTR_ST0_MASK;
            OFF_ST0_FLAGS: reg_attr = ATTR_ST0_FLAGS;
            OFF_ST0_CONFIG: reg_attr = ATTR_ST0_CONFIG;
            OFF_ST2_MASK: reg_attr = ATTR_ST2_MASK;
            OFF_ST2_FLAGS: reg_attr = ATTR_ST2_FLAGS;
            OFF_SPI_STATUS: reg_attr = ATTR_SPI_STATUS;
            OFF_ST0_CMP_RA_HI, OFF_ST2_CMP_SB_HI: reg_attr = ATTR_LOW4;
            OFF_PB_DIR, OFF_PB_OUT, OFF_PD_DIR, OFF_PD_OUT,
            OFF_ST0_CONTROL, OFF_ST2_CONFIG, OFF_ST2_CONTROL,
            OFF_SPI_CONTROL, OFF_SCRATCH0, OFF_SCRATCH1, OFF_SCRATCH2,
            OFF_ST0_CMP_RB_HI, OFF_ST2_CMP_SB_LO, OFF_ST2_CMP_RB_LO,
            OFF_ST2_CMP_RB_HI, OFF_ST0_CMP_RA_LO: reg_attr = ATTR_FULL;
            default: reg_attr = ATTR_NONE; // reserved addresses hold nothing
        endcase
    endfunction : reg_attr

    // live hardware levels shown in read-only bit positions
    function automatic logic [7:0] hw_level(input logic [5:0] idx, input hw_in_type hw);
        case (idx)
            OFF_PB_PINS: hw_level = hw.pin_b;
            OFF_PD_PINS: hw_level = hw.pin_d;
            OFF_PE_PINS: hw_level = {5'h00, hw.pin_e};
            OFF_ACOMP_STATUS: hw_level = 8'({hw.ac_level, 1'b0});
            OFF_ST0_FLAGS: hw_level = 8'({hw.stage0_status, 1'b0});
            OFF_ST2_FLAGS: hw_level = 8'({hw.stage2_status, 1'b0});
            default: hw_level = 8'h00;
        endcase
    endfunction : hw_level

    // one-cycle event pulses that set sticky flags
    function automatic logic [7:0] hw_event(input logic [5:0] idx, input hw_in_type hw);
        case (idx)
            OFF_ACOMP_STATUS: hw_event = 8'(hw.ac_event) << ACOMP_FLAG_LSB;
            OFF_T1_FLAGS: hw_event = (8'(hw.t1_capture) << T1_CAPTURE_BIT)
                | (8'(hw.t1_overflow) << T1_OVERFLOW_BIT);
            OFF_ADC_CSA: hw_event = 8'(hw.adc_done) << ADC_DONE_BIT;
            OFF_SPI_STATUS: hw_event = (8'(hw.spi_done) << SPI_DONE_BIT)
                | (8'(hw.spi_collision) << SPI_COLL_BIT);
            OFF_ST0_FLAGS: hw_event = hw.stage0_event;
            OFF_ST2_FLAGS: hw_event = hw.stage2_event;
            default: hw_event = 8'h00;
        endcase
    endfunction : hw_event

    logic [IO_SPAN-1:0][7:0] io_r;
    logic [IO_SPAN-1:0][7:0] io_nxt;
    logic [7:0] ext_r [0:EXT_WORDS-1];
    rsp_type rsp_r;
    rsp_type rsp_nxt;

    // access decode
    logic is_io_op;
    logic is_bit_op;
    logic is_skip_op;
    logic is_mem_op;
    logic is_write;
    logic hit_io;
    logic hit_ext;
    logic [5:0] io_idx;
    logic [7:0] ext_idx;
    logic [7:0] bit_mask;

    // route each operation to the i/o array, the extended array or nowhere
    always_comb begin
        is_io_op = REQ_I.op == OP_IO_READ || REQ_I.op == OP_IO_WRITE;
        is_bit_op = REQ_I.op == OP_BIT_SET || REQ_I.op == OP_BIT_CLEAR;
        is_skip_op = REQ_I.op == OP_SKIP_HIGH || REQ_I.op == OP_SKIP_LOW;
        is_mem_op = REQ_I.op == OP_MEM_LOAD || REQ_I.op == OP_MEM_STORE;
        is_write = REQ_I.op == OP_IO_WRITE || REQ_I.op == OP_MEM_STORE;
        hit_io = 1'b0;
        hit_ext = 1'b0;
        io_idx = REQ_I.addr[5:0];
        ext_idx = 8'h00;
        bit_mask = 8'h01 << REQ_I.bit_sel;
        if (REQ_I.valid) begin
            if ((is_bit_op || is_skip_op) && REQ_I.addr <= BIT_IO_LAST) begin
                hit_io = 1'b1;
            end else if (is_io_op && REQ_I.addr <= IO_LAST) begin
                hit_io = 1'b1;
            end else if (is_mem_op && REQ_I.addr >= DATA_IO_OFFSET
                         && REQ_I.addr < EXT_FIRST) begin
                hit_io = 1'b1;
                io_idx = 6'(REQ_I.addr - DATA_IO_OFFSET);
            end else if (is_mem_op && REQ_I.addr >= EXT_FIRST
                         && 8'(REQ_I.addr - EXT_FIRST) < 8'(EXT_WORDS)) begin
                hit_ext = 1'b1;
                ext_idx = 8'(REQ_I.addr - EXT_FIRST);
            end
        end
    end

    // per-register next value; hardware sets win over a same-cycle clear
    generate
        for (genvar g = 0; g < IO_SPAN; g++) begin : g_io
            reg_attr_type attr;
            logic [7:0] rw_bits;
            logic hit;
            always_comb begin
                attr = reg_attr(6'(g));
                rw_bits = attr.impl & ~attr.w1c & ~attr.hw;
                hit = hit_io && io_idx == 6'(g);
                io_nxt[g] = io_r[g];
                if (hit && is_write) begin
                    io_nxt[g] = (io_r[g] & ~rw_bits) | (REQ_I.wdata & rw_bits);
                    io_nxt[g] = io_nxt[g] & ~(REQ_I.wdata & attr.w1c);
                end else if (hit && REQ_I.op == OP_BIT_SET) begin
                    // only the target bit moves; a flag there is cleared
                    io_nxt[g] = io_r[g] | (bit_mask & rw_bits);
                    io_nxt[g] = io_nxt[g] & ~(bit_mask & attr.w1c);
                end else if (hit && REQ_I.op == OP_BIT_CLEAR) begin
                    // writing zero to a flag position leaves the flag
                    io_nxt[g] = io_r[g] & ~(bit_mask & rw_bits);
                end
                io_nxt[g] = (io_nxt[g] & ~attr.hw) | (hw_level(6'(g), HW_I) & attr.hw);
                io_nxt[g] = io_nxt[g] | (hw_event(6'(g), HW_I) & attr.w1c);
                io_nxt[g] = io_nxt[g] & attr.impl;
            end
        end
    endgenerate

    // answer: data, skip condition and refusal, one cycle after the request
    always_comb begin
        rsp_nxt = '0;
        rsp_nxt.done = REQ_I.valid;
        rsp_nxt.refused = REQ_I.valid && !hit_io && !hit_ext;
        if (hit_io && !is_write) begin
            rsp_nxt.rdata = io_r[io_idx];
        end else if (hit_ext && !is_write) begin
            rsp_nxt.rdata = ext_r[ext_idx];
        end
        if (hit_io && REQ_I.op == OP_SKIP_HIGH) begin
            rsp_nxt.bit_true = |(io_r[io_idx] & bit_mask);
        end else if (hit_io && REQ_I.op == OP_SKIP_LOW) begin
            rsp_nxt.bit_true = ~|(io_r[io_idx] & bit_mask);
        end
    end

    // state registers
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            io_r <= {IO_SPAN{IO_RESET}};
            rsp_r <= '0;
        end else begin
            io_r <= io_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    // extended space storage; no reset so it maps onto plain ram
    always_ff @(posedge CLK_I) begin
        if (hit_ext && is_write) begin
            ext_r[ext_idx] <= REQ_I.wdata;
        end
    end

    assign RSP_O = rsp_r;
    assign IO_REGS_O = io_r;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    AST_BIT_SET_TARGET: assert property (
        REQ_I.valid && REQ_I.op == OP_BIT_SET && REQ_I.addr == 8'(OFF_SCRATCH0)
        |=> io_r[OFF_SCRATCH0] == ($past(io_r[OFF_SCRATCH0]) | (8'h01 << $past(REQ_I.bit_sel))))
        else $error("bit set did not change only the target bit");

    AST_BIT_CLEAR_TARGET: assert property (
        REQ_I.valid && REQ_I.op == OP_BIT_CLEAR && REQ_I.addr == 8'(OFF_SCRATCH2)
        |=> io_r[OFF_SCRATCH2] == ($past(io_r[OFF_SCRATCH2]) & ~(8'h01 << $past(REQ_I.bit_sel))))
        else $error("bit clear did not change only the target bit");

    AST_SKIP_HIGH_RESULT: assert property (
        REQ_I.valid && REQ_I.op == OP_SKIP_HIGH && REQ_I.addr == 8'(OFF_SPI_STATUS)
        && REQ_I.bit_sel == 3'(SPI_DONE_BIT)
        |=> RSP_O.done && RSP_O.bit_true == $past(io_r[OFF_SPI_STATUS][SPI_DONE_BIT]))
        else $error("skip test returned the wrong bit state");

    AST_W1C_ONE_CLEARS: assert property (
        REQ_I.valid && REQ_I.op == OP_IO_WRITE && REQ_I.addr == 8'(OFF_T1_FLAGS)
        && REQ_I.wdata[T1_OVERFLOW_BIT] && !HW_I.t1_overflow
        |=> !io_r[OFF_T1_FLAGS][T1_OVERFLOW_BIT])
        else $error("written one did not clear the flag");

    AST_W1C_ZERO_KEEPS: assert property (
        REQ_I.valid && REQ_I.op == OP_IO_WRITE && REQ_I.addr == 8'(OFF_T1_FLAGS)
        && io_r[OFF_T1_FLAGS][T1_CAPTURE_BIT] && !REQ_I.wdata[T1_CAPTURE_BIT]
        |=> io_r[OFF_T1_FLAGS][T1_CAPTURE_BIT])
        else $error("written zero disturbed a flag");

    AST_NEIGHBOUR_FLAG_KEPT: assert property (
        REQ_I.valid && REQ_I.op == OP_BIT_SET && REQ_I.addr == 8'(OFF_SPI_STATUS)
        && REQ_I.bit_sel == 3'(SPI_DOUBLE_BIT) && io_r[OFF_SPI_STATUS][SPI_DONE_BIT]
        |=> io_r[OFF_SPI_STATUS][SPI_DONE_BIT] && io_r[OFF_SPI_STATUS][SPI_DOUBLE_BIT])
        else $error("bit set cleared a neighbouring flag");

    AST_BIT_OP_RANGE: assert property (
        REQ_I.valid && (REQ_I.op == OP_BIT_SET || REQ_I.op == OP_BIT_CLEAR)
        && REQ_I.addr > BIT_IO_LAST
        |=> RSP_O.refused && $stable(io_r[OFF_ST0_CMP_RB_HI]))
        else $error("bit operation accepted above the low range");

    AST_IO_OP_RANGE: assert property (
        REQ_I.valid && is_io_op |=> RSP_O.refused == ($past(REQ_I.addr) > IO_LAST))
        else $error("i/o port range decoded wrongly");

    AST_MEM_OFFSET: assert property (
        REQ_I.valid && REQ_I.op == OP_MEM_STORE
        && REQ_I.addr == 8'(OFF_SCRATCH1) + DATA_IO_OFFSET
        |=> io_r[OFF_SCRATCH1] == $past(REQ_I.wdata))
        else $error("store did not reach the offset i/o register");

    AST_EXT_MEM_ONLY: assert property (
        REQ_I.valid && is_io_op && REQ_I.addr >= EXT_FIRST |=> RSP_O.refused)
        else $error("extended range reached by an i/o port operation");

    AST_SPI_FLAG_LAYOUT: assert property (
        HW_I.spi_done && HW_I.spi_collision
        |=> io_r[OFF_SPI_STATUS][SPI_DONE_BIT] && io_r[OFF_SPI_STATUS][SPI_COLL_BIT])
        else $error("serial events not at their bit positions");

    AST_T1_FLAG_LAYOUT: assert property (
        HW_I.t1_capture && HW_I.t1_overflow
        |=> io_r[OFF_T1_FLAGS][T1_CAPTURE_BIT]
        && io_r[OFF_T1_FLAGS][T1_OVERFLOW_BIT])
        else $error("timer events not at their bit positions");

    AST_UNIMPL_ZERO: assert property (
        (io_r[OFF_T1_FLAGS] & ~ATTR_T1_FLAGS.impl) == 8'h00
        && (io_r[OFF_SPI_STATUS] & ~ATTR_SPI_STATUS.impl) == 8'h00
        && io_r[6'h30] == 8'h00)
        else $error("unimplemented bit reads nonzero");

    // an event landing with its clearing write must survive, or it is lost
    AST_EVENT_BEATS_CLEAR: assert property (
        HW_I.spi_done && REQ_I.valid && REQ_I.op == OP_IO_WRITE
        && REQ_I.addr == 8'(OFF_SPI_STATUS)
        |=> io_r[OFF_SPI_STATUS][SPI_DONE_BIT])
        else $error("flag event lost to a clearing write");

    AST_BIT_CLEAR_KEEPS_FLAG: assert property (
        REQ_I.valid && REQ_I.op == OP_BIT_CLEAR
        && REQ_I.addr == 8'(OFF_SPI_STATUS)
        && REQ_I.bit_sel == 3'(SPI_DONE_BIT)
        && io_r[OFF_SPI_STATUS][SPI_DONE_BIT]
        |=> io_r[OFF_SPI_STATUS][SPI_DONE_BIT])
        else $error("bit clear disturbed a flag");

    // clearing one flag by bit set must spare the flag beside it
    AST_BIT_SET_ONE_FLAG: assert property (
        REQ_I.valid && REQ_I.op == OP_BIT_SET
        && REQ_I.addr == 8'(OFF_SPI_STATUS)
        && REQ_I.bit_sel == 3'(SPI_COLL_BIT) && !HW_I.spi_collision
        |=> !io_r[OFF_SPI_STATUS][SPI_COLL_BIT]
        && io_r[OFF_SPI_STATUS][SPI_DONE_BIT]
        == $past(io_r[OFF_SPI_STATUS][SPI_DONE_BIT] | HW_I.spi_done))
        else $error("bit set on a flag disturbed its neighbour");

    AST_SKIP_LOW_RESULT: assert property (
        REQ_I.valid && REQ_I.op == OP_SKIP_LOW
        && REQ_I.addr == 8'(OFF_SCRATCH1)
        |=> RSP_O.done
        && RSP_O.bit_true == !$past(io_r[OFF_SCRATCH1][REQ_I.bit_sel]))
        else $error("skip-if-low returned the wrong bit state");

    AST_SKIP_OP_RANGE: assert property (
        REQ_I.valid && is_skip_op && REQ_I.addr > BIT_IO_LAST
        |=> RSP_O.refused && !RSP_O.bit_true)
        else $error("skip test accepted above the low range");

    AST_IO_READ_DATA: assert property (
        REQ_I.valid && REQ_I.op == OP_IO_READ
        && REQ_I.addr == 8'(OFF_SCRATCH0)
        |=> RSP_O.rdata == $past(io_r[OFF_SCRATCH0]))
        else $error("i/o read returned the wrong byte");

    AST_MEM_LOAD_OFFSET: assert property (
        REQ_I.valid && REQ_I.op == OP_MEM_LOAD
        && REQ_I.addr == 8'(OFF_SCRATCH2) + DATA_IO_OFFSET
        |=> RSP_O.rdata == $past(io_r[OFF_SCRATCH2]))
        else $error("load did not read the offset i/o register");

    // below the offset sits the core's register file, not this block
    AST_MEM_LOW_REFUSED: assert property (
        REQ_I.valid && is_mem_op && REQ_I.addr < DATA_IO_OFFSET
        |=> RSP_O.refused)
        else $error("load or store below the offset accepted");

    AST_EXT_MEM_TAKEN: assert property (
        REQ_I.valid && is_mem_op && REQ_I.addr >= EXT_FIRST
        |=> !RSP_O.refused)
        else $error("load or store in the extended range refused");

    AST_T1_MASK_LAYOUT: assert property (
        REQ_I.valid && REQ_I.op == OP_IO_WRITE && REQ_I.addr == 8'(OFF_T1_MASK)
        |=> io_r[OFF_T1_MASK][T1_CAPTURE_BIT] == $past(REQ_I.wdata[T1_CAPTURE_BIT])
        && io_r[OFF_T1_MASK][T1_OVERFLOW_BIT] == $past(REQ_I.wdata[T1_OVERFLOW_BIT]))
        else $error("timer mask bits not at their positions");

    COV_BIT_SET_ON_FLAGS: cover property (
        REQ_I.valid && REQ_I.op == OP_BIT_SET && REQ_I.addr == 8'(OFF_T1_FLAGS));
    COV_SKIP_LOW_TRUE: cover property (
        REQ_I.valid && REQ_I.op == OP_SKIP_LOW ##1 RSP_O.bit_true);
    COV_EXT_STORE_LOAD: cover property (
        REQ_I.valid && REQ_I.op == OP_MEM_STORE && REQ_I.addr >= EXT_FIRST
        ##2 REQ_I.valid && REQ_I.op == OP_MEM_LOAD && REQ_I.addr >= EXT_FIRST);
    COV_SET_BEATS_CLEAR: cover property (
        HW_I.spi_done && REQ_I.valid && REQ_I.op == OP_IO_WRITE
        && REQ_I.addr == 8'(OFF_SPI_STATUS) && REQ_I.wdata[SPI_DONE_BIT]);

endmodule : io_register_space_decode

// >>> rtl/io_space_pkg.sv
// constants, types and register attributes for the i/o register space decoder
package io_space_pkg;

    localparam int IO_SPAN = 64;
    localparam int EXT_DEPTH = 160;

    // address windows, in core address terms
    localparam logic [7:0] BIT_IO_LAST = 8'h1F;
    localparam logic [7:0] IO_LAST = 8'h3F;
    localparam logic [7:0] DATA_IO_OFFSET = 8'h20;
    localparam logic [7:0] EXT_FIRST = 8'h60;
    localparam logic [7:0] EXT_LAST = 8'hFF;
    localparam logic [7:0] IO_RESET = 8'h00;

    // i/o offsets
    localparam logic [5:0] OFF_ACOMP_STATUS = 6'h00;
    localparam logic [5:0] OFF_T1_MASK = 6'h01;
    localparam logic [5:0] OFF_T1_FLAGS = 6'h02;
    localparam logic [5:0] OFF_PB_PINS = 6'h03;
    localparam logic [5:0] OFF_PB_DIR = 6'h04;
    localparam logic [5:0] OFF_PB_OUT = 6'h05;
    localparam logic [5:0] OFF_ADC_CSA = 6'h06;
    localparam logic [5:0] OFF_ADC_CSB = 6'h07;
    localparam logic [5:0] OFF_ADC_CHSEL = 6'h08;
    localparam logic [5:0] OFF_PD_PINS = 6'h09;
    localparam logic [5:0] OFF_PD_DIR = 6'h0A;
    localparam logic [5:0] OFF_PD_OUT = 6'h0B;
    localparam logic [5:0] OFF_PE_PINS = 6'h0C;
    localparam logic [5:0] OFF_PE_DIR = 6'h0D;
    localparam logic [5:0] OFF_PE_OUT = 6'h0E;
    localparam logic [5:0] OFF_ST0_MASK = 6'h0F;
    localparam logic [5:0] OFF_ST0_FLAGS = 6'h10;
    localparam logic [5:0] OFF_ST0_CONFIG = 6'h11;
    localparam logic [5:0] OFF_ST0_CONTROL = 6'h12;
    localparam logic [5:0] OFF_ST2_MASK = 6'h13;
    localparam logic [5:0] OFF_ST2_FLAGS = 6'h14;
    localparam logic [5:0] OFF_ST2_CONFIG = 6'h15;
    localparam logic [5:0] OFF_ST2_CONTROL = 6'h16;
    localparam logic [5:0] OFF_SPI_CONTROL = 6'h17;
    localparam logic [5:0] OFF_SPI_STATUS = 6'h18;
    localparam logic [5:0] OFF_SCRATCH0 = 6'h19;
    localparam logic [5:0] OFF_SCRATCH1 = 6'h1A;
    localparam logic [5:0] OFF_SCRATCH2 = 6'h1B;
    localparam logic [5:0] OFF_ST0_CMP_RB_HI = 6'h25;
    localparam logic [5:0] OFF_ST2_CMP_SB_LO = 6'h26;
    localparam logic [5:0] OFF_ST2_CMP_SB_HI = 6'h27;
    localparam logic [5:0] OFF_ST2_CMP_RB_LO = 6'h28;
    localparam logic [5:0] OFF_ST2_CMP_RB_HI = 6'h29;
    localparam logic [5:0] OFF_ST0_CMP_RA_LO = 6'h2A;
    localparam logic [5:0] OFF_ST0_CMP_RA_HI = 6'h2B;

    // field positions
    localparam int SPI_DONE_BIT = 7;
    localparam int SPI_COLL_BIT = 6;
    localparam int SPI_DOUBLE_BIT = 0;
    localparam int T1_CAPTURE_BIT = 5;
    localparam int T1_OVERFLOW_BIT = 0;
    localparam int ADC_DONE_BIT = 4;
    localparam int ACOMP_FLAG_LSB = 5;
    localparam int ACOMP_LEVEL_LSB = 1;
    localparam int STAGE_STATUS_LSB = 1;

    typedef struct packed {
        logic [7:0] impl; // bits that exist
        logic [7:0] w1c;  // flags cleared by writing one
        logic [7:0] hw;   // bits that mirror hardware state
    } reg_attr_type;

    localparam reg_attr_type ATTR_NONE = '{8'h00, 8'h00, 8'h00};
    localparam reg_attr_type ATTR_FULL = '{8'hFF, 8'h00, 8'h00};
    localparam reg_attr_type ATTR_PINS8 = '{8'hFF, 8'h00, 8'hFF};
    localparam reg_attr_type ATTR_PINS3 = '{8'h07, 8'h00, 8'h07};
    localparam reg_attr_type ATTR_LOW3 = '{8'h07, 8'h00, 8'h00};
    localparam reg_attr_type ATTR_LOW4 = '{8'h0F, 8'h00, 8'h00};
    localparam reg_attr_type ATTR_ACOMP = '{8'hEE, 8'hE0, 8'h0E};
    localparam reg_attr_type ATTR_T1_MASK = '{8'h21, 8'h00, 8'h00};
    localparam reg_attr_type ATTR_T1_FLAGS = '{8'h21, 8'h21, 8'h00};
    localparam reg_attr_type ATTR_ADC_CSA = '{8'hFF, 8'h10, 8'h00};
    localparam reg_attr_type ATTR_ADC_CSB = '{8'hDF, 8'h00, 8'h00};
    localparam reg_attr_type ATTR_ADC_CHSEL = '{8'hEF, 8'h00, 8'h00};
    localparam reg_attr_type ATTR_ST0_MASK = '{8'h1B, 8'h00, 8'h00};
    localparam reg_attr_type ATTR_ST0_FLAGS = '{8'hDF, 8'hD9, 8'h06};
    localparam reg_attr_type ATTR_ST0_CONFIG = '{8'hFE, 8'h00, 8'h00};
    localparam reg_attr_type ATTR_ST2_MASK = '{8'h3B, 8'h00, 8'h00};
    localparam reg_attr_type ATTR_ST2_FLAGS = '{8'hFF, 8'hF9, 8'h06};
    localparam reg_attr_type ATTR_SPI_STATUS = '{8'hC1, 8'hC0, 8'h00};

    typedef enum logic [2:0] {
        OP_IO_READ,
        OP_IO_WRITE,
        OP_BIT_SET,
        OP_BIT_CLEAR,
        OP_SKIP_HIGH,
        OP_SKIP_LOW,
        OP_MEM_LOAD,
        OP_MEM_STORE
    } op_type;

    typedef struct packed {
        logic valid;
        op_type op;
        logic [7:0] addr;    // i/o address, or data address for load/store
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } req_type;

    typedef struct packed {
        logic done;
        logic refused;
        logic bit_true;      // skip condition met
        logic [7:0] rdata;
    } rsp_type;

    typedef struct packed {
        logic [7:0] pin_b;
        logic [7:0] pin_d;
        logic [2:0] pin_e;
        logic [2:0] ac_level;
        logic [2:0] ac_event;
        logic t1_capture;
        logic t1_overflow;
        logic adc_done;
        logic spi_done;
        logic spi_collision;
        logic [7:0] stage0_event;
        logic [1:0] stage0_status;
        logic [7:0] stage2_event;
        logic [1:0] stage2_status;
    } hw_in_type;

endpackage : io_space_pkg

// >>> bench/core_model.sv
// core-side model: issues one i/o request at a time and keeps the answer
`timescale 1ns/1ns
module core_model
    import io_space_pkg::*;
(
    input wire logic clk_i,
    input wire rsp_type rsp_i,
    output req_type req_o
);
    rsp_type last_rsp;

    // bus idle until the first request, which only comes after reset release
    initial req_o = '0;

    // valid stands for exactly the edge that takes it; answer read one cycle on
    task automatic xfer(input op_type op, input logic [7:0] addr, input logic [2:0] bsel,
        input logic [7:0] wdata);
        @(posedge clk_i);
        req_o <= '{1'b1, op, addr, bsel, wdata};
        @(posedge clk_i);
        req_o.valid <= 1'b0;
        #1;
        last_rsp = rsp_i;
    endtask : xfer
endmodule : core_model

// >>> bench/tb_top.sv
// self-checking bench for the i/o register space decoder
`timescale 1ns/1ns
module tb_top;
    import io_space_pkg::*;
    logic clk_i;
    logic rst_i;
    req_type req;
    rsp_type rsp;
    hw_in_type hw;
    logic [IO_SPAN-1:0][7:0] regs;
    int err_total;
    int total_checks;
    int cycles = 0;
    logic [7:0] mdl [256]; // expected image, indexed by data address
    op_type rop [8] = '{OP_BIT_SET, OP_BIT_CLEAR, OP_SKIP_HIGH, OP_SKIP_LOW,
        OP_IO_READ, OP_IO_WRITE, OP_MEM_LOAD, OP_MEM_STORE};
    logic [7:0] rad [8] = '{8'h25, 8'h3F, 8'h20, 8'h25, 8'h40, 8'h60, 8'h1F, 8'h00};

    io_register_space_decode DUT (.CLK_I(clk_i), .RST_I(rst_i), .REQ_I(req), .HW_I(hw),
        .RSP_O(rsp), .IO_REGS_O(regs));
    core_model core (.clk_i(clk_i), .rsp_i(rsp), .req_o(req));

    // core clock, 100 ns period
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // writable bits and write-one-to-clear bits of the registers the bench uses
    function automatic logic [15:0] attr(input logic [7:0] da);
        case (da)
            8'h21: attr = 16'h2100;
            8'h22: attr = 16'h2121;
            8'h38: attr = 16'hC1C0;
            8'h23, 8'h29, 8'h2C: attr = 16'h0000;
            default: attr = 16'hFF00;
        endcase
    endfunction : attr

    // byte write into model and design; read-only places keep their value
    task automatic wr(input op_type op, input logic [7:0] a, input logic [7:0] v);
        logic [7:0] da;
        logic [15:0] at;
        da = (op == OP_MEM_STORE) ? a : a + 8'h20;
        at = attr(da);
        if (at[15:8] != 8'h00) begin
            v = v & at[15:8];
            mdl[da] = (mdl[da] & at[7:0] & ~v) | (v & ~at[7:0]);
        end
        core.xfer(op, a, 3'h0, v); // callers never pass a reserved address
        chk("write done", 8'h01, 8'(core.last_rsp.done));
    endtask : wr

    task automatic rd(input op_type op, input logic [7:0] a);
        logic [7:0] da;
        da = (op == OP_MEM_LOAD) ? a : a + 8'h20;
        core.xfer(op, a, 3'h0, 8'h00);
        chk("read done", 8'h01, 8'(core.last_rsp.done));
        chk("read data", mdl[da], core.last_rsp.rdata);
    endtask : rd

    // one bit op, then both skip tests on the same bit
    task automatic bop(input op_type op, input logic [7:0] a, input logic [2:0] b);
        logic [15:0] at;
        logic [7:0] m;
        logic [7:0] da;
        da = a + 8'h20;
        at = attr(da);
        m = 8'h01 << b;
        core.xfer(op, a, b, 8'h00);
        if (op == OP_BIT_SET) begin
            mdl[da] = at[b] ? mdl[da] & ~m : mdl[da] | (m & at[15:8]);
        end else if (!at[b]) begin
            mdl[da] = mdl[da] & ~m;
        end
        chk("bit op image", mdl[da], regs[a[5:0]]);
        core.xfer(OP_SKIP_HIGH, a, b, 8'h00);
        chk("skip high", 8'(mdl[da][b]), 8'(core.last_rsp.bit_true));
        core.xfer(OP_SKIP_LOW, a, b, 8'h00);
        chk("skip low", 8'(!mdl[da][b]), 8'(core.last_rsp.bit_true));
    endtask : bop

    // main sequence
    initial begin
        logic [7:0] v;
        rst_i = 1'b1;
        hw = '0;
        err_total = 0;
        total_checks = 0;
        v = 8'($urandom(32'h6CC0));
        for (int i = 0; i < 256; i++) mdl[i] = 8'h00;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        for (int i = 0; i < IO_SPAN; i++) chk("reset image", 8'h00, regs[i]);
        for (int k = 0; k < 3; k++) begin
            v = 8'($urandom);
            wr(OP_IO_WRITE, 8'h19 + 8'(k), v);
            rd(OP_MEM_LOAD, 8'h39 + 8'(k));
            wr(OP_MEM_STORE, 8'h39 + 8'(k), ~v);
            rd(OP_IO_READ, 8'h19 + 8'(k));
            for (int b = 0; b < 8; b++) begin
                v = 8'($urandom);
                bop(v[0] ? OP_BIT_SET : OP_BIT_CLEAR, 8'h19 + 8'(k), 3'(b));
            end
        end
        // extended space, then every op outside its window
        v = 8'($urandom);
        wr(OP_MEM_STORE, 8'h60, v);
        wr(OP_MEM_STORE, 8'hFF, ~v);
        rd(OP_MEM_LOAD, 8'h60);
        rd(OP_MEM_LOAD, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            core.xfer(rop[i], rad[i], 3'h0, 8'h5A);
            chk("refused", 8'h01, 8'(core.last_rsp.refused));
            chk("refused data", 8'h00, core.last_rsp.rdata);
        end
        chk("above bit range", 8'h00, regs[6'h25]);
        // timer flags: both events, then clear one at a time
        @(posedge clk_i);
        hw.t1_capture <= 1'b1;
        hw.t1_overflow <= 1'b1;
        @(posedge clk_i);
        hw.t1_capture <= 1'b0;
        hw.t1_overflow <= 1'b0;
        mdl[8'h22] = 8'h21;
        rd(OP_IO_READ, 8'h02);
        wr(OP_IO_WRITE, 8'h02, 8'h00);
        rd(OP_IO_READ, 8'h02);
        wr(OP_IO_WRITE, 8'h02, 8'h01);
        rd(OP_IO_READ, 8'h02);
        bop(OP_BIT_SET, 8'h02, 3'h0);
        wr(OP_MEM_STORE, 8'h22, 8'h20);
        rd(OP_IO_READ, 8'h02);
        wr(OP_IO_WRITE, 8'h01, 8'hFF);
        rd(OP_MEM_LOAD, 8'h21);
        // serial flags beside a control bit: bit ops must spare neighbours
        @(posedge clk_i);
        hw.spi_done <= 1'b1;
        hw.spi_collision <= 1'b1;
        @(posedge clk_i);
        hw.spi_done <= 1'b0;
        hw.spi_collision <= 1'b0;
        mdl[8'h38] = 8'hC0;
        bop(OP_BIT_SET, 8'h18, 3'h0);
        bop(OP_BIT_CLEAR, 8'h18, 3'h7);
        bop(OP_BIT_SET, 8'h18, 3'h6);
        bop(OP_BIT_CLEAR, 8'h18, 3'h0);
        // event in the cycle of its clearing write: the event wins
        fork
            begin
                @(posedge clk_i);
                hw.spi_done <= 1'b1;
                @(posedge clk_i);
                hw.spi_done <= 1'b0;
            end
        join_none
        wr(OP_IO_WRITE, 8'h18, 8'h80);
        mdl[8'h38] = 8'h80;
        rd(OP_IO_READ, 8'h18);
        wr(OP_IO_WRITE, 8'h18, 8'h80);
        rd(OP_IO_READ, 8'h18);
        // pin levels: writes ignored, absent bits read zero
        v = 8'($urandom);
        @(posedge clk_i);
        hw.pin_b <= v;
        hw.pin_d <= ~v;
        hw.pin_e <= v[7:5];
        mdl[8'h23] = v;
        mdl[8'h29] = ~v;
        mdl[8'h2C] = {5'h00, v[7:5]};
        wr(OP_IO_WRITE, 8'h03, ~v);
        rd(OP_IO_READ, 8'h03);
        rd(OP_MEM_LOAD, 8'h29);
        rd(OP_IO_READ, 8'h0C);
        end_of_test();
    end
endmodule : tb_top
